/* File: csf_top.sv */
/*
  CPU status flag unit: flag register, watchdog divider select, watchdog
  with reset on overflow, APB slave for both registers.
  Assumes CPU strobes come from logic on pclk; APB master on pclk.
*/
// What this block does
// - One 8-bit register holds zero, carry, half carry, wrap, sleep, expiry.
// - Register writes change zero, carry, half carry and wrap flags.
// - Register writes never change the sleep or expiry flags.
// - Carry set on add carry or subtract without borrow, else cleared.
// - Rotate through carry feeds carry in and loads shifted-out bit.
// - Half carry set on low-nibble carry or no nibble borrow.
// - Zero flag follows whether an arithmetic or logic result is zero.
// - Wrap flag is carry into msb xor carry out of msb.
// - Sleep flag cleared by power-up or watchdog clear, set by sleep.
// - Expiry flag cleared by power-up, clear, sleep; set by time-out.
// - Calls and interrupt entry never save or alter the flags.
// - Watchdog counter overflow issues a device reset.
// - Low three divider select bits choose divide by 1 to 128.
`timescale 1ns/10ps
`include "csf_params.svh"
module csf_top
  import csf_pkg::*;
#(
  parameter int WDT_CNT_W = `CSF_WDT_CNT_W
)
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic alu_valid,
  input wire csf_alu_req_type alu_req,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instruction,
  // Results
  output logic [7:0] alu_result,
  output logic [7:0] flags,
  output logic wdt_reset
);

  logic c_q;
  logic ac_q;
  logic z_q;
  logic ov_q;
  logic sleep_q;
  logic exp_q;
  logic [7:0] wds_q;
  logic [7:0] alu_result_q;
  logic wdt_reset_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  csf_flags_type flag_view;
  csf_alu_res_type res;
  logic wdt_ovf;
  logic setup;
  logic commit;
  logic hit_flag;
  logic hit_wds;
  logic wr_flag;
  logic wr_wds;
  logic [8:0] chk_sum;
  // Reset image of the flag register, one bit taken per arithmetic flag
  localparam logic [7:0] FLAG_RST = `CSF_FLAG_RESET;

  // APB decode; a transfer completes in the access cycle where pready is set
  assign setup = psel & ~penable;
  assign commit = psel & penable & pready_q;
  assign hit_flag = (paddr == `CSF_FLAG_ADDR);
  assign hit_wds = (paddr == `CSF_WDS_ADDR);
  assign wr_flag = ce & commit & pwrite & hit_flag;
  assign wr_wds = ce & commit & pwrite & hit_wds;

  assign flag_view = '{
    rsvd: 2'b00,
    watchdog_expired_flag: exp_q,
    sleep_entered_flag: sleep_q,
    signed_wrap_flag: ov_q,
    z: z_q,
    half_carry_flag: ac_q,
    c: c_q
  };

  // Outputs all come from flip-flops
  assign flags = flag_view;
  assign alu_result = alu_result_q;
  assign wdt_reset = wdt_reset_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  csf_alu_flags u_alu (
    .req (alu_req),
    .carry_in (c_q),
    .res (res)
  );

  csf_wdt #(
    .CNT_W (WDT_CNT_W)
  ) u_wdt (
    .pclk (pclk),
    .presetn (presetn),
    .ce (ce),
    .clear (watchdog_clear_instruction | sleep_instr),
    .div_sel (wds_q[`CSF_WDS_SEL_W-1:0]),
    .overflow (wdt_ovf)
  );

  // APB answer: ready one cycle after setup, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~(hit_flag | hit_wds);
      if (setup & ~pwrite & hit_flag)
        prdata_q <= {24'h000000, flag_view};
      else if (setup & ~pwrite & hit_wds)
        prdata_q <= {24'h000000, wds_q};
      else
        prdata_q <= 32'h00000000;
    end
  end

  // Arithmetic flags: the ALU outranks a same-cycle register write per flag
  // no call path here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c_q <= FLAG_RST[`CSF_C_BIT];
      ac_q <= FLAG_RST[`CSF_AC_BIT];
      z_q <= FLAG_RST[`CSF_Z_BIT];
      ov_q <= FLAG_RST[`CSF_OV_BIT];
    end
    else if (ce)
    begin
      if (alu_valid & res.upd_c)
        c_q <= res.c;
      else if (wr_flag)
        c_q <= pwdata[`CSF_C_BIT];
      if (alu_valid & res.upd_acov)
      begin
        ac_q <= res.ac;
        ov_q <= res.ov;
      end
      else if (wr_flag)
      begin
        ac_q <= pwdata[`CSF_AC_BIT];
        ov_q <= pwdata[`CSF_OV_BIT];
      end
      if (alu_valid & res.upd_z)
        z_q <= res.z;
      else if (wr_flag)
        z_q <= pwdata[`CSF_Z_BIT];
    end
  end

  // ALU result register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alu_result_q <= 8'h00;
    else if (ce & alu_valid)
      alu_result_q <= res.result;
  end

  // Sleep flag: register writes do not reach it, set beats clear
  // sleep flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_q <= 1'b0;
    else if (ce)
    begin
      if (sleep_instr)
        sleep_q <= 1'b1;
      else if (watchdog_clear_instruction)
        sleep_q <= 1'b0;
    end
  end

  // Expiry flag: a time-out in the same cycle as a clear is kept
  // expiry flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exp_q <= 1'b0;
    else if (ce)
    begin
      if (wdt_ovf)
        exp_q <= 1'b1;
      else if (watchdog_clear_instruction | sleep_instr)
        exp_q <= 1'b0;
    end
  end

  // Divider select, all eight bits stored, low three used
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wds_q <= `CSF_WDS_RESET;
    else if (wr_wds)
      wds_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_reset_q <= 1'b0;
    else if (ce)
      wdt_reset_q <= wdt_ovf;
  end

  // Reference sum for checking
  assign chk_sum = {1'b0, alu_req.a} + {1'b0, alu_req.b};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    ce && setup;
  endsequence

  sequence s_access;
    pready;
  endsequence

  property p_apb_ready;
    s_setup |=> s_access;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb access not ready one cycle after setup");

  property p_wr_keeps_sys;
    wr_flag && !sleep_instr && !watchdog_clear_instruction && !wdt_ovf
      |=> $stable(sleep_q) && $stable(exp_q);
  endproperty
  a_wr_keeps_sys: assert property (p_wr_keeps_sys)
    else $error("register write changed sleep or expiry flag");

  property p_wr_carry;
    wr_flag && !alu_valid |=> c_q == $past(pwdata[`CSF_C_BIT]);
  endproperty
  a_wr_carry: assert property (p_wr_carry)
    else $error("register write did not load carry");

  property p_add_carry;
    ce && alu_valid && alu_req.op == CSF_OP_ADD
      |=> c_q == $past(chk_sum[8]) && alu_result == $past(chk_sum[7:0]);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry or result wrong");

  property p_rlc;
    ce && alu_valid && alu_req.op == CSF_OP_RLC
      |=> c_q == $past(alu_req.a[7]) && alu_result[0] == $past(c_q);
  endproperty
  a_rlc: assert property (p_rlc)
    else $error("rotate through carry wrong");

  property p_and_zero;
    ce && alu_valid && alu_req.op == CSF_OP_AND
      |=> z_q == ($past(alu_req.a & alu_req.b) == 8'h00);
  endproperty
  a_and_zero: assert property (p_and_zero)
    else $error("zero flag wrong after and");

  property p_sleep_set;
    ce && sleep_instr && !wdt_ovf |=> sleep_q && !exp_q;
  endproperty
  a_sleep_set: assert property (p_sleep_set)
    else $error("sleep did not set sleep flag and clear expiry");

  property p_clear;
    ce && watchdog_clear_instruction && !sleep_instr && !wdt_ovf
      |=> !sleep_q && !exp_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("watchdog clear did not clear flags");

  property p_timeout;
    ce && wdt_ovf
      |=> (exp_q && wdt_reset) ##1 (!wdt_reset || !$past(ce));
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out did not set expiry and pulse reset");

  property p_rsvd_zero;
    flags[7:6] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("undefined flag bits not zero");

endmodule

/* File: csf_params.svh */
/*
  Constants of the status flag unit: register offsets, flag bit positions,
  reset values. Assumes inclusion by bare name from the unit's files.
*/
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// Register byte offsets on the APB
`define CSF_FLAG_ADDR 12'h000
`define CSF_WDS_ADDR 12'h004

// Flag register bit positions
`define CSF_C_BIT 0
`define CSF_AC_BIT 1
`define CSF_Z_BIT 2
`define CSF_OV_BIT 3
`define CSF_SLEEP_BIT 4
`define CSF_EXP_BIT 5

// Reset values
`define CSF_FLAG_RESET 8'h00
`define CSF_WDS_RESET 8'h07

// Watchdog divider select field width, counter width default
`define CSF_WDS_SEL_W 3
`define CSF_WDT_CNT_W 8

`endif

/* File: csf_pkg.sv */
/*
  Types of the status flag unit: ALU opcodes, request, result and the
  packed flag register view. Assumes csf_params.svh for bit positions.
*/
package csf_pkg;

  // Operations that update the flags
  typedef enum logic [2:0] {
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_AND,
    CSF_OP_OR,
    CSF_OP_XOR,
    CSF_OP_RLC,
    CSF_OP_RRC
  } csf_op_type;

  typedef struct packed {
    csf_op_type op;
    logic [7:0] a;
    logic [7:0] b;
  } csf_alu_req_type;

  typedef struct packed {
    logic [7:0] result;
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic upd_c;
    logic upd_acov;
    logic upd_z;
  } csf_alu_res_type;

  // Flag register layout, bit 0 is the carry flag
  typedef struct packed {
    logic [1:0] rsvd;
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic signed_wrap_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } csf_flags_type;

endpackage

/* File: csf_alu_flags.sv */
/*
  Combinational flag generator: from an ALU request and the current carry
  it forms the result and the new carry, half carry, zero and signed wrap
  flags, with a mask of which flags the operation touches.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
module csf_alu_flags
  import csf_pkg::*;
(
  // Request
  input wire csf_alu_req_type req,
  input wire logic carry_in,
  // Result
  output csf_alu_res_type res
);

  logic [7:0] b_eff;
  logic cin0;
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] low7;

  // Subtract is add of inverted operand plus one; carry then means no borrow
  assign b_eff = (req.op == CSF_OP_SUB) ? ~req.b : req.b;
  assign cin0 = (req.op == CSF_OP_SUB);
  assign full = {1'b0, req.a} + {1'b0, b_eff} + {8'h00, cin0};
  assign low = {1'b0, req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin0};
  assign low7 = {1'b0, req.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin0};

  // Flag formation per operation
  always_comb
  begin
    res = '0;
    case (req.op)
      CSF_OP_ADD, CSF_OP_SUB:
      begin
        res.result = full[7:0];
        res.c = full[8];
        res.ac = low[4];
        res.ov = low7[7] ^ full[8];
        res.z = (full[7:0] == 8'h00);
        res.upd_c = 1'b1;
        res.upd_acov = 1'b1;
        res.upd_z = 1'b1;
      end
      CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR:
      begin
        if (req.op == CSF_OP_AND)
          res.result = req.a & req.b;
        else if (req.op == CSF_OP_OR)
          res.result = req.a | req.b;
        else
          res.result = req.a ^ req.b;
        res.z = (res.result == 8'h00);
        res.upd_z = 1'b1;
      end
      CSF_OP_RLC:
      begin
        res.result = {req.a[6:0], carry_in};
        res.c = req.a[7];
        res.upd_c = 1'b1;
      end
      CSF_OP_RRC:
      begin
        res.result = {carry_in, req.a[7:1]};
        res.c = req.a[0];
        res.upd_c = 1'b1;
      end
      default:
      begin
        res = '0;
      end
    endcase
  end

endmodule

/* File: csf_wdt.sv */
/*
  Watchdog prescaler and counter. The prescaler divides the clock by 2 to
  the power of the select, the counter overflows and pulses overflow.
  Assumes the caller registers overflow and drives clear from decode.
*/
`timescale 1ns/10ps
`include "csf_params.svh"
module csf_wdt
  import csf_pkg::*;
#(
  parameter int CNT_W = `CSF_WDT_CNT_W
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic [`CSF_WDS_SEL_W-1:0] div_sel,
  // Event
  output logic overflow
);

  logic [6:0] pre_q;
  logic [6:0] mask;
  logic tick;
  logic [CNT_W-1:0] cnt_q;

  assign mask = 7'((8'h01 << div_sel) - 8'h01);
  assign tick = ce & ((pre_q & mask) == mask);
  assign overflow = tick & (&cnt_q);

  // Prescaler, restarted by clear so a kick gives a full period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 7'h00;
    else if (ce)
      pre_q <= clear ? 7'h00 : pre_q + 7'h01;
  end

  // Counter wraps to zero on overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (ce)
    begin
      if (clear)
        cnt_q <= '0;
      else if (tick)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_div1_tick;
    ce && !clear && div_sel == 3'h0
      |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1);
  endproperty
  a_div1_tick: assert property (p_div1_tick)
    else $error("divide by one did not tick");

  property p_div128_gap;
    ce && div_sel == 3'h7 && pre_q != 7'h7F && !clear |=> $stable(cnt_q);
  endproperty
  a_div128_gap: assert property (p_div128_gap)
    else $error("divide by 128 ticked early");

endmodule

/* File: csf_top_tb.sv */
/*
  Self-checking bench for the status flag unit: APB register access, ALU
  flag updates, sleep and watchdog clear strobes, watchdog time-outs.
  Assumes csf_top with a short watchdog counter and one 200 MHz clock.
*/
`timescale 1ns/10ps
`include "csf_params.svh"
module csf_top_tb
  import csf_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alu_valid = 1'b0;
  csf_alu_req_type alu_req = '0;
  logic sleep_instr = 1'b0;
  logic watchdog_clear_instruction = 1'b0;
  logic [7:0] alu_result;
  logic [7:0] flags;
  logic wdt_reset;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] exp_f = 8'h00;
  int n;

  // Short counter so a time-out takes 2^sel * 8 cycles
  csf_top #(.WDT_CNT_W(3)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_req(alu_req), .sleep_instr(sleep_instr),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .alu_result(alu_result), .flags(flags), .wdt_reset(wdt_reset)
  );

  // Clock, 5 ns period
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic final_report;
    begin
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    begin
      checks_done++;
      if (got !== exp)
      begin
        errors++;
        $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask

  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    begin
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // If pready never rises, only the bench watchdog ends this wait
      while (pready !== 1'b1)
      begin
        @(posedge pclk);
        k++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(8'(k), 8'h00, "apb wait states");
      @(negedge pclk);
    end
  endtask

  // One-cycle strobes of sleep and watchdog clear
  task automatic strobe(input logic slp, input logic clr);
    begin
      @(posedge pclk);
      sleep_instr <= slp;
      watchdog_clear_instruction <= clr;
      @(posedge pclk);
      sleep_instr <= 1'b0;
      watchdog_clear_instruction <= 1'b0;
      @(negedge pclk);
    end
  endtask

  // Expected result and flags are formed here, then the op is issued
  task automatic alu_do(input csf_op_type op, input logic [7:0] a,
                        input logic [7:0] b);
    logic [8:0] s;
    logic [7:0] r;
    logic [7:0] f;
    begin
      f = exp_f;
      r = 8'h00;
      s = {1'b0, a} + {1'b0, b};
      case (op)
        CSF_OP_ADD:
        begin
          r = s[7:0];
          f[0] = s[8];
          f[1] = (5'(a[3:0]) + 5'(b[3:0])) > 5'h0F;
          f[3] = (a[7] == b[7]) && (r[7] != a[7]);
        end
        CSF_OP_SUB:
        begin
          r = a - b;
          f[0] = a >= b;
          f[1] = a[3:0] >= b[3:0];
          f[3] = (a[7] != b[7]) && (r[7] != a[7]);
        end
        CSF_OP_AND: r = a & b;
        CSF_OP_OR: r = a | b;
        CSF_OP_XOR: r = a ^ b;
        CSF_OP_RLC:
        begin
          r = {a[6:0], f[0]};
          f[0] = a[7];
        end
        CSF_OP_RRC:
        begin
          r = {f[0], a[7:1]};
          f[0] = a[0];
        end
        default: r = 8'h00;
      endcase
      if (op != CSF_OP_RLC && op != CSF_OP_RRC)
        f[2] = (r == 8'h00);
      @(posedge pclk);
      alu_valid <= 1'b1;
      alu_req <= '{op: op, a: a, b: b};
      @(posedge pclk);
      alu_valid <= 1'b0;
      @(negedge pclk);
      exp_f = f;
      chk(alu_result, r, "alu result");
      chk(flags & 8'hCF, f & 8'h0F, "alu flags");
    end
  endtask

  task automatic t_reset;
    begin
      chk(flags, `CSF_FLAG_RESET, "flags at reset");
      apb(1'b0, `CSF_FLAG_ADDR, 32'h0);
      chk(rd[7:0], 8'h00, "flag reg read");
      apb(1'b0, `CSF_WDS_ADDR, 32'h0);
      chk(rd[7:0], `CSF_WDS_RESET, "divider reset");
    end
  endtask

  task automatic t_write;
    begin
      apb(1'b1, `CSF_FLAG_ADDR, 32'h000000FF);
      chk(flags, 8'h0F, "flag write");
      apb(1'b0, `CSF_FLAG_ADDR, 32'h0);
      chk(rd[7:0], 8'h0F, "flag readback");
      apb(1'b1, `CSF_FLAG_ADDR, 32'h00000000);
      chk(flags, 8'h00, "flag clear write");
      exp_f = 8'h00;
    end
  endtask

  task automatic t_sleep;
    begin
      strobe(1'b1, 1'b0);
      chk({6'h0, flags[5:4]}, 8'h01, "sleep sets");
      apb(1'b1, `CSF_FLAG_ADDR, 32'h00000000);
      chk({6'h0, flags[5:4]}, 8'h01, "write keeps sleep");
      strobe(1'b0, 1'b1);
      chk({6'h0, flags[5:4]}, 8'h00, "clear instr");
    end
  endtask

  task automatic t_alu;
    begin
      alu_do(CSF_OP_ADD, 8'hFF, 8'h01);
      alu_do(CSF_OP_ADD, 8'h7F, 8'h01);
      alu_do(CSF_OP_ADD, 8'h80, 8'h80);
      alu_do(CSF_OP_ADD, 8'h0E, 8'h01);
      alu_do(CSF_OP_SUB, 8'h05, 8'h03);
      alu_do(CSF_OP_SUB, 8'h03, 8'h05);
      alu_do(CSF_OP_SUB, 8'h10, 8'h01);
      alu_do(CSF_OP_SUB, 8'h80, 8'h01);
      alu_do(CSF_OP_SUB, 8'h44, 8'h44);
      alu_do(CSF_OP_AND, 8'hF0, 8'h0F);
      alu_do(CSF_OP_OR, 8'h00, 8'h01);
      alu_do(CSF_OP_XOR, 8'h5A, 8'h5A);
      alu_do(CSF_OP_RLC, 8'h80, 8'h00);
      alu_do(CSF_OP_RLC, 8'h01, 8'h00);
      alu_do(CSF_OP_RRC, 8'h01, 8'h00);
      alu_do(CSF_OP_RRC, 8'h02, 8'h00);
    end
  endtask

  task automatic wait_rst;
    begin
      n = 0;
      while (wdt_reset !== 1'b1 && n < 60)
      begin
        @(negedge pclk);
        n++;
      end
    end
  endtask

  task automatic t_wdt;
    begin
      apb(1'b1, `CSF_WDS_ADDR, 32'h000000F8);
      apb(1'b0, `CSF_WDS_ADDR, 32'h0);
      chk(rd[7:0], 8'hF8, "divider rw");
      strobe(1'b0, 1'b1);
      wait_rst;
      chk({7'h0, n >= 5 && n <= 11}, 8'h01, "period div 1");
      @(negedge pclk);
      chk({6'h0, flags[5:4]}, 8'h02, "time-out sets");
      apb(1'b1, `CSF_WDS_ADDR, 32'h00000007);
      apb(1'b1, `CSF_FLAG_ADDR, 32'h00000000);
      chk({6'h0, flags[5:4]}, 8'h02, "write keeps expiry");
      strobe(1'b1, 1'b0);
      chk({6'h0, flags[5:4]}, 8'h01, "sleep clears expiry");
      apb(1'b1, `CSF_WDS_ADDR, 32'h000000FA);
      strobe(1'b0, 1'b1);
      chk({6'h0, flags[5:4]}, 8'h00, "clear both");
      wait_rst;
      chk({7'h0, n >= 28 && n <= 36}, 8'h01, "period div 4");
      apb(1'b1, `CSF_WDS_ADDR, 32'h00000007);
    end
  endtask

  // Mid-run power-up clears sleep and expiry, divider back to reset
  task automatic t_powerup;
    begin
      apb(1'b1, `CSF_WDS_ADDR, 32'h000000F8);
      strobe(1'b1, 1'b0);
      wait_rst;
      @(negedge pclk);
      chk({6'h0, flags[5:4]}, 8'h03, "sleep and expiry set");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(flags, `CSF_FLAG_RESET, "flags after power-up");
      apb(1'b0, `CSF_WDS_ADDR, 32'h0);
      chk(rd[7:0], `CSF_WDS_RESET, "divider after power-up");
    end
  endtask

  task automatic t_unmapped;
    begin
      apb(1'b0, 12'h008, 32'h0);
      chk({7'h0, er}, 8'h01, "unmapped error");
      chk(rd[7:0], 8'h00, "unmapped data");
    end
  endtask

  // Main sequence, reset held for two cycles
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset;
    t_write;
    t_sleep;
    t_alu;
    t_wdt;
    t_powerup;
    t_unmapped;
    final_report;
  end

  // Hang guard, far beyond the 150 or so cycles the tests need
  initial
  begin
    #20000;
    errors++;
    $display("[FAIL] %0t run did not finish", $time);
    final_report;
  end
endmodule
